//--- shared/gfe_pkg.sv
// constants, field layout and mode codes for the gpio function and enable output block
// assumes one clock domain; users import gfe_pkg::*
// Notes on behaviour
// - in fault-indicator mode a sequencing fault asserts GPIO6, pulls enables low, saves log
// - raise pin low with lower high picks raise set; reverse picks lower; else nominal
// - raise or lower set closes all trim switches and enables margining automatically
// - nominal set leaves trim switch state to the DAC enable configuration bits
// - margin function is on while suspend input is low or software margin bit set
// - margin function freezes fault lines and reset, ignores violations, suppresses logging
// - manual reset input low holds the reset output asserted
// - after manual reset rises, reset stays asserted for the configured timeout
// - GPIO6 becomes watchdog expiry output when the three config bits read 110
// - GPIO5 becomes watchdog kick input when its three config bits read 111
// - watchdog expiry output is open-drain active-low
// - enables one to four take 3-bit codes; 110 and 111 reserved
// - enables five and six use same codes, but tracking code 100 is reserved
// - enables seven to nine take 2-bit open-drain or push-pull codes
// - low mode register holds enable one, two and low bits of enable three
// - middle register holds enable three top, four, five, and enable six low bit
// - high register holds enable six top bits, seven, eight and nine codes
package gfe_pkg;
  localparam logic [7:0] GFE_OFS_MODE_LOW = 8'h1f;
  localparam logic [7:0] GFE_OFS_MODE_MID = 8'h20;
  localparam logic [7:0] GFE_OFS_MODE_HIGH = 8'h21;
  localparam logic [7:0] GFE_RST_MODE_LOW = 8'h00;
  localparam logic [7:0] GFE_RST_MODE_MID = 8'h00;
  localparam logic [7:0] GFE_RST_MODE_HIGH = 8'h00;
  // field positions inside the mode registers
  localparam int GFE_EN1_LSB = 0;
  localparam int GFE_EN2_LSB = 3;
  localparam int GFE_EN3_LO_LSB = 6;
  localparam int GFE_EN3_HI_BIT = 0;
  localparam int GFE_EN4_LSB = 1;
  localparam int GFE_EN5_LSB = 4;
  localparam int GFE_EN6_LO_BIT = 7;
  localparam int GFE_EN6_HI_LSB = 0;
  localparam int GFE_EN7_LSB = 2;
  localparam int GFE_EN8_LSB = 4;
  localparam int GFE_EN9_LSB = 6;
  // channel counts and capabilities
  localparam int GFE_NUM_EN = 9;
  localparam int GFE_NUM_TRACK = 4;
  localparam int GFE_NUM_WIDE = 6;
  localparam int GFE_NUM_DAC = 12;
  localparam int GFE_TMO_W = 24;
  // enable output mode codes
  localparam logic [2:0] GFE_MODE_OD_LOW = 3'h0;
  localparam logic [2:0] GFE_MODE_OD_HIGH = 3'h1;
  localparam logic [2:0] GFE_MODE_PP_LOW = 3'h2;
  localparam logic [2:0] GFE_MODE_PP_HIGH = 3'h3;
  localparam logic [2:0] GFE_MODE_TRACK = 3'h4;
  localparam logic [2:0] GFE_MODE_PUMP = 3'h5;
  // trim set selection codes
  localparam logic [1:0] GFE_SET_NOMINAL = 2'h0;
  localparam logic [1:0] GFE_SET_RAISE = 2'h1;
  localparam logic [1:0] GFE_SET_LOWER = 2'h2;
  // GPIO6 function select and watchdog patterns
  localparam logic [1:0] GFE_G6_NONE = 2'h0;
  localparam logic [1:0] GFE_G6_FAULT_PU = 2'h1;
  localparam logic [1:0] GFE_G6_SUSPEND = 2'h2;
  localparam logic [2:0] GFE_WDO_PATTERN = 3'h6;
  localparam logic [2:0] GFE_WDI_PATTERN = 3'h7;
  // pin positions inside the GPIO input vector (GPIO1 at 0)
  localparam int GFE_GPIO_RAISE = 1;
  localparam int GFE_GPIO_LOWER = 2;
  localparam int GFE_GPIO_MR = 3;
  localparam int GFE_GPIO_KICK = 4;
  localparam int GFE_GPIO_SIX = 5;

  // true when a code is not usable on the given channel
  function automatic logic gfe_mode_reserved(input logic [2:0] mode, input int idx);
    logic rsv;
    rsv = 1'b0;
    if (idx >= GFE_NUM_WIDE) begin
      rsv = mode[2];
    end else if (mode > GFE_MODE_PUMP) begin
      rsv = 1'b1;
    end else if (idx >= GFE_NUM_TRACK && mode == GFE_MODE_TRACK) begin
      rsv = 1'b1;
    end
    return rsv;
  endfunction
endpackage

//--- shared/gfe_en_if.sv
// signals between the control core and one enable output driver
// assumes both ends run on the same clock and reset
`timescale 1ns/1ps
`default_nettype none
interface gfe_en_if (
  input wire logic clk,
  input wire logic rst
);
  logic [2:0] mode;
  logic assert_req;
  logic force_low;
  logic pin_o;
  logic pin_oe;
  logic track;
  logic pump;
  modport ctrl (output mode, output assert_req, output force_low,
                input pin_o, input pin_oe, input track, input pump);
  modport drv (input clk, input rst, input mode, input assert_req, input force_low,
               output pin_o, output pin_oe, output track, output pump);
endinterface
`default_nettype wire

//--- hdl/gfe_sync.sv
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module gfe_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end
  assign q = sync_r;
endmodule
`default_nettype wire

//--- hdl/gfe_en_drv.sv
// one enable output driver: mode decode and registered pin drive
// assumes the core supplies mode, request and force-low on the same clock
`timescale 1ns/1ps
`default_nettype none
module gfe_en_drv
  import gfe_pkg::*;
#(
  parameter int IDX = 0
) (
  gfe_en_if.drv en
);
  logic rsv_w;
  logic a_w;
  logic o_nxt, oe_nxt, track_nxt, pump_nxt;
  logic o_r, oe_r, track_r, pump_r;

  assign rsv_w = gfe_mode_reserved(en.mode, IDX);
  assign a_w = en.assert_req;

  // pin level and enable from the mode code
  always_comb begin
    o_nxt = 1'b0;
    oe_nxt = 1'b0;
    track_nxt = 1'b0;
    pump_nxt = 1'b0;
    if (en.force_low) begin
      oe_nxt = 1'b1; // forced low in every mode
    end else if (rsv_w) begin
      oe_nxt = 1'b0;
    end else begin
      unique case (en.mode)
        GFE_MODE_OD_LOW: oe_nxt = a_w;
        GFE_MODE_OD_HIGH: oe_nxt = !a_w;
        GFE_MODE_PP_LOW: begin
          oe_nxt = 1'b1;
          o_nxt = !a_w;
        end
        GFE_MODE_PP_HIGH: begin
          oe_nxt = 1'b1;
          o_nxt = a_w;
        end
        GFE_MODE_TRACK: track_nxt = a_w;
        default: pump_nxt = a_w;
      endcase
    end
  end

  // registered drive
  always_ff @(posedge en.clk or posedge en.rst) begin
    if (en.rst) begin
      o_r <= 1'b0;
      oe_r <= 1'b0;
      track_r <= 1'b0;
      pump_r <= 1'b0;
    end else begin
      o_r <= o_nxt;
      oe_r <= oe_nxt;
      track_r <= track_nxt;
      pump_r <= pump_nxt;
    end
  end
  assign en.pin_o = o_r;
  assign en.pin_oe = oe_r;
  assign en.track = track_r;
  assign en.pump = pump_r;

  default clocking cb @(posedge en.clk); endclocking
  default disable iff (en.rst);

  chk_reserved_released: assert property (rsv_w && !en.force_low |=> !oe_r && !track_r && !pump_r)
    else $error("reserved mode drove the enable pin");
  chk_push_pull_high: assert property (en.mode == GFE_MODE_PP_HIGH && !en.force_low
      |=> oe_r && o_r == $past(a_w))
    else $error("push-pull active-high level wrong");
endmodule
`default_nettype wire

//--- hdl/gfe_core.sv
// gpio special functions and supply-enable output configuration
// assumes pins arrive unsynchronised; config, sequencer and watchdog inputs share REF_CLK
`timescale 1ns/1ps
`default_nettype none
module gfe_core
  import gfe_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR_EN,
  input wire logic [7:0] REG_WR_DATA,
  output logic [7:0] REG_RD_DATA,
  input wire logic MARGIN_PINS_CFG,
  input wire logic MR_CFG,
  input wire logic [1:0] GPIO6_FUNC,
  input wire logic [1:0] WDT_CFG_HI,
  input wire logic WDT_CFG_LO,
  input wire logic [2:0] WDI_CFG,
  input wire logic [GFE_NUM_DAC-1:0] DAC_EN_CFG,
  input wire logic SW_MARGIN,
  input wire logic [5:0] GPIO_IN,
  input wire logic SEQ_FAULT,
  input wire logic FAULT_PU_CLEAR,
  input wire logic WDT_EXPIRED,
  input wire logic [GFE_TMO_W-1:0] RST_TIMEOUT_CYC,
  input wire logic FAULT_LINE_ONE_IN,
  input wire logic FAULT_LINE_TWO_IN,
  input wire logic ANY_FAULT_IN,
  input wire logic RESET_REQ_IN,
  input wire logic [GFE_NUM_EN-1:0] EN_REQ,
  output logic [1:0] DAC_SET_SEL,
  output logic [GFE_NUM_DAC-1:0] DAC_SW_CLOSED,
  output logic MARGIN_ACTIVE,
  output logic FAULT_LINE_ONE_OUT,
  output logic FAULT_LINE_TWO_OUT,
  output logic ANY_FAULT_OUT,
  output logic RESET_N_OUT,
  output logic FAULT_LOG_SAVE,
  output logic GPIO6_OUT,
  output logic GPIO6_OE,
  output logic WD_KICK,
  output logic [GFE_NUM_EN-1:0] EN_OUT_O,
  output logic [GFE_NUM_EN-1:0] EN_OUT_OE,
  output logic [GFE_NUM_EN-1:0] EN_TRACK,
  output logic [GFE_NUM_EN-1:0] EN_PUMP
);
  logic [5:0] gpio_s;
  logic [7:0] mode_low_r, mode_mid_r, mode_high_r;
  logic [7:0] rd_nxt, rd_r;
  logic wr_low_w, wr_mid_w, wr_high_w;
  logic wdo_sel_w, wdi_sel_w, fpu_sel_w, susp_sel_w;
  logic raise_w, lower_w;
  logic [1:0] set_nxt, set_r;
  logic [GFE_NUM_DAC-1:0] sw_nxt, sw_r;
  logic susp_low_w, margin_en_w, margin_r;
  logic f1_r, f2_r, anyf_r, rst_n_r;
  logic fpu_set_w, fpu_r, save_r;
  logic mr_low_w, mr_active_w, reset_req_w;
  logic [GFE_TMO_W-1:0] mr_cnt_r;
  logic g6_oe_nxt, g6_oe_r, kick_r;
  logic [2:0] mode_w [GFE_NUM_EN];
  logic [GFE_NUM_EN-1:0] o_w, oe_w, track_w, pump_w;

  // pins pass two flops before use
  gfe_sync #(.W(6)) u_pin_sync (
    .clk(REF_CLK),
    .rst(RST),
    .d(GPIO_IN),
    .q(gpio_s)
  );

  // register decode
  assign wr_low_w = REG_WR_EN && REG_ADDR == GFE_OFS_MODE_LOW;
  assign wr_mid_w = REG_WR_EN && REG_ADDR == GFE_OFS_MODE_MID;
  assign wr_high_w = REG_WR_EN && REG_ADDR == GFE_OFS_MODE_HIGH;

  // mode register storage
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mode_low_r <= GFE_RST_MODE_LOW;
      mode_mid_r <= GFE_RST_MODE_MID;
      mode_high_r <= GFE_RST_MODE_HIGH;
    end else begin
      if (wr_low_w) mode_low_r <= REG_WR_DATA;
      if (wr_mid_w) mode_mid_r <= REG_WR_DATA;
      if (wr_high_w) mode_high_r <= REG_WR_DATA;
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    unique case (REG_ADDR)
      GFE_OFS_MODE_LOW: rd_nxt = mode_low_r;
      GFE_OFS_MODE_MID: rd_nxt = mode_mid_r;
      GFE_OFS_MODE_HIGH: rd_nxt = mode_high_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  // per-channel mode fields, split codes joined here
  assign mode_w[0] = mode_low_r[GFE_EN1_LSB +: 3];
  assign mode_w[1] = mode_low_r[GFE_EN2_LSB +: 3];
  assign mode_w[2] = {mode_mid_r[GFE_EN3_HI_BIT], mode_low_r[GFE_EN3_LO_LSB +: 2]};
  assign mode_w[3] = mode_mid_r[GFE_EN4_LSB +: 3];
  assign mode_w[4] = mode_mid_r[GFE_EN5_LSB +: 3];
  assign mode_w[5] = {mode_high_r[GFE_EN6_HI_LSB +: 2], mode_mid_r[GFE_EN6_LO_BIT]};
  assign mode_w[6] = {1'b0, mode_high_r[GFE_EN7_LSB +: 2]};
  assign mode_w[7] = {1'b0, mode_high_r[GFE_EN8_LSB +: 2]};
  assign mode_w[8] = {1'b0, mode_high_r[GFE_EN9_LSB +: 2]};

  // GPIO5 and GPIO6 function selection; watchdog pattern wins GPIO6
  assign wdo_sel_w = {WDT_CFG_HI, WDT_CFG_LO} == GFE_WDO_PATTERN;
  assign wdi_sel_w = WDI_CFG == GFE_WDI_PATTERN;
  assign fpu_sel_w = !wdo_sel_w && GPIO6_FUNC == GFE_G6_FAULT_PU;
  assign susp_sel_w = !wdo_sel_w && GPIO6_FUNC == GFE_G6_SUSPEND;

  // trim set choice from the margin pins
  assign raise_w = gpio_s[GFE_GPIO_RAISE];
  assign lower_w = gpio_s[GFE_GPIO_LOWER];
  always_comb begin
    set_nxt = GFE_SET_NOMINAL;
    if (MARGIN_PINS_CFG && !raise_w && lower_w) begin
      set_nxt = GFE_SET_RAISE;
    end else if (MARGIN_PINS_CFG && raise_w && !lower_w) begin
      set_nxt = GFE_SET_LOWER;
    end
  end
  assign sw_nxt = (set_nxt != GFE_SET_NOMINAL) ? '1 : DAC_EN_CFG;

  // margin function and output freeze
  assign susp_low_w = susp_sel_w && !gpio_s[GFE_GPIO_SIX];
  assign margin_en_w = susp_low_w || SW_MARGIN || set_nxt != GFE_SET_NOMINAL;

  // manual reset hold and timeout
  assign mr_low_w = MR_CFG && !gpio_s[GFE_GPIO_MR];
  assign mr_active_w = mr_low_w || mr_cnt_r != '0;
  assign reset_req_w = RESET_REQ_IN || mr_active_w;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mr_cnt_r <= '0;
    end else if (mr_low_w) begin
      mr_cnt_r <= RST_TIMEOUT_CYC;
    end else if (mr_cnt_r != '0) begin
      mr_cnt_r <= mr_cnt_r - GFE_TMO_W'(1);
    end
  end

  // fault-on-power-up latch; set beats clear, ignored while margining
  assign fpu_set_w = fpu_sel_w && SEQ_FAULT && !margin_en_w;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      fpu_r <= 1'b0;
      save_r <= 1'b0;
    end else begin
      fpu_r <= fpu_set_w || (fpu_r && !FAULT_PU_CLEAR && fpu_sel_w);
      save_r <= fpu_set_w && !fpu_r;
    end
  end

  // GPIO6 open-drain drive for watchdog expiry or fault indicator
  assign g6_oe_nxt = wdo_sel_w ? WDT_EXPIRED : (fpu_sel_w && fpu_r);

  // registered outputs; frozen lines hold while margining
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rd_r <= 8'h00;
      set_r <= GFE_SET_NOMINAL;
      sw_r <= '0;
      margin_r <= 1'b0;
      f1_r <= 1'b0;
      f2_r <= 1'b0;
      anyf_r <= 1'b0;
      rst_n_r <= 1'b0;
      g6_oe_r <= 1'b0;
      kick_r <= 1'b0;
    end else begin
      rd_r <= rd_nxt;
      set_r <= set_nxt;
      sw_r <= sw_nxt;
      margin_r <= margin_en_w;
      if (!margin_en_w) begin
        f1_r <= FAULT_LINE_ONE_IN;
        f2_r <= FAULT_LINE_TWO_IN;
        anyf_r <= ANY_FAULT_IN;
        rst_n_r <= !reset_req_w;
      end
      g6_oe_r <= g6_oe_nxt;
      kick_r <= wdi_sel_w && gpio_s[GFE_GPIO_KICK];
    end
  end

  // enable output drivers
  gfe_en_if en_if [GFE_NUM_EN] (.clk(REF_CLK), .rst(RST));
  for (genvar i = 0; i < GFE_NUM_EN; i++) begin : g_en
    assign en_if[i].mode = mode_w[i];
    assign en_if[i].assert_req = EN_REQ[i];
    assign en_if[i].force_low = fpu_r;
    assign o_w[i] = en_if[i].pin_o;
    assign oe_w[i] = en_if[i].pin_oe;
    assign track_w[i] = en_if[i].track;
    assign pump_w[i] = en_if[i].pump;
    gfe_en_drv #(.IDX(i)) u_drv (
      .en(en_if[i])
    );
  end

  // output ports
  assign REG_RD_DATA = rd_r;
  assign DAC_SET_SEL = set_r;
  assign DAC_SW_CLOSED = sw_r;
  assign MARGIN_ACTIVE = margin_r;
  assign FAULT_LINE_ONE_OUT = f1_r;
  assign FAULT_LINE_TWO_OUT = f2_r;
  assign ANY_FAULT_OUT = anyf_r;
  assign RESET_N_OUT = rst_n_r;
  assign FAULT_LOG_SAVE = save_r;
  assign GPIO6_OUT = 1'b0;
  assign GPIO6_OE = g6_oe_r;
  assign WD_KICK = kick_r;
  assign EN_OUT_O = o_w;
  assign EN_OUT_OE = oe_w;
  assign EN_TRACK = track_w;
  assign EN_PUMP = pump_w;

  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_mr_rise;
    MR_CFG && $past(mr_low_w) && !mr_low_w;
  endsequence
  sequence s_fault_event;
    fpu_sel_w && SEQ_FAULT && !margin_en_w && !fpu_r;
  endsequence

  chk_fault_forces_low: assert property (fpu_r |=> EN_OUT_OE == '1 && EN_OUT_O == '0)
    else $error("enables not pulled low on power-up fault");
  chk_fault_save_pulse: assert property (s_fault_event |=> FAULT_LOG_SAVE ##1 !FAULT_LOG_SAVE)
    else $error("fault save pulse missing or too long");
  chk_trim_raise: assert property (MARGIN_PINS_CFG && !raise_w && lower_w |=> DAC_SET_SEL == GFE_SET_RAISE)
    else $error("raise set not selected");
  chk_trim_equal: assert property (raise_w == lower_w |=> DAC_SET_SEL == GFE_SET_NOMINAL)
    else $error("equal pins did not select nominal set");
  chk_switch_closed: assert property (set_nxt != GFE_SET_NOMINAL |=> DAC_SW_CLOSED == '1 && MARGIN_ACTIVE)
    else $error("trim switches not closed in margin set");
  chk_switch_follows: assert property (!RST && set_nxt == GFE_SET_NOMINAL |=> DAC_SW_CLOSED == $past(DAC_EN_CFG))
    else $error("trim switches ignore enable bits");
  chk_margin_enable: assert property (susp_low_w || SW_MARGIN |=> MARGIN_ACTIVE)
    else $error("margin function not enabled");
  chk_freeze_hold: assert property (MARGIN_ACTIVE |-> $stable(FAULT_LINE_ONE_OUT) && $stable(FAULT_LINE_TWO_OUT)
      && $stable(ANY_FAULT_OUT) && $stable(RESET_N_OUT))
    else $error("frozen line changed while margining");
  chk_mr_hold: assert property (mr_low_w && !margin_en_w |=> !RESET_N_OUT)
    else $error("reset not asserted by manual reset");
  chk_mr_timeout: assert property (s_mr_rise |-> mr_cnt_r == $past(RST_TIMEOUT_CYC))
    else $error("timeout not loaded on manual reset release");
  chk_mr_count: assert property (mr_cnt_r != '0 && !margin_en_w |=> !RESET_N_OUT)
    else $error("reset released before timeout ended");
  chk_wdo_drive: assert property (wdo_sel_w |=> GPIO6_OE == $past(WDT_EXPIRED) && !GPIO6_OUT)
    else $error("watchdog expiry pin drive wrong");
  chk_wdi_route: assert property (wdi_sel_w |=> WD_KICK == $past(gpio_s[GFE_GPIO_KICK]))
    else $error("kick input not routed");
  chk_wdi_off: assert property (!wdi_sel_w |=> !WD_KICK)
    else $error("kick passed while not configured");
  chk_mode_layout: assert property (wr_mid_w |=> mode_w[3] == $past(REG_WR_DATA[GFE_EN4_LSB +: 3]))
    else $error("enable four field misplaced");
endmodule
`default_nettype wire

//--- sim/gfe_board.sv
// board side of the pins: pull-ups on open-drain lines, pin levels set by the bench
// assumes every released enable line and gpio6 carry an external pull-up
`timescale 1ns/1ps
`default_nettype none
module gfe_board
  import gfe_pkg::*;
(
  input wire logic [5:0] pin_req,
  input wire logic gpio6_out,
  input wire logic gpio6_oe,
  input wire logic [GFE_NUM_EN-1:0] en_out_o,
  input wire logic [GFE_NUM_EN-1:0] en_out_oe,
  output logic [5:0] gpio_in,
  output logic [GFE_NUM_EN-1:0] en_pin
);
  // gpio6 pulled up, low while the device sinks it; suspend held high outside margining
  assign gpio_in = {pin_req[5] & ~(gpio6_oe & ~gpio6_out), pin_req[4:0]};
  // released enable lines float up to the pull-up level
  assign en_pin = (en_out_oe & en_out_o) | ~en_out_oe;
endmodule
`default_nettype wire

//--- sim/tb_gfe_core.sv
// self-checking bench for the gpio function and enable output block
// assumes the board model supplies pull-ups; all inputs driven at rising edges
`timescale 1ns/1ps
`default_nettype none
module tb_gfe_core;
  import gfe_pkg::*;
  logic ref_clk, rst = 1'b1, reg_wr_en = 1'b0, margin_pins_cfg = 1'b0, mr_cfg = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data;
  logic [1:0] gpio6_func = 2'h0, wdt_cfg_hi = 2'h0, dac_set_sel;
  logic wdt_cfg_lo = 1'b0, sw_margin = 1'b0, seq_fault = 1'b0, fault_pu_clear = 1'b0, wdt_expired = 1'b0;
  logic [2:0] wdi_cfg = 3'h0;
  logic [11:0] dac_en_cfg = 12'ha5c, dac_sw_closed;
  logic [23:0] rst_timeout_cyc = 24'h00000a;
  logic fault_line_one_in = 1'b0, fault_line_two_in = 1'b0, any_fault_in = 1'b0, reset_req_in = 1'b0;
  logic [8:0] en_req = 9'h000, en_out_o, en_out_oe, en_track, en_pump, en_pin;
  logic [5:0] pin_req = 6'h3f, gpio_in;
  logic margin_active, fault_line_one_out, fault_line_two_out, any_fault_out, reset_n_out, fault_log_save;
  logic gpio6_out, gpio6_oe, wd_kick;
  int err_count = 0;
  int n_checks = 0;

  gfe_core gfe_core_i (.REF_CLK(ref_clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WR_EN(reg_wr_en),
    .REG_WR_DATA(reg_wr_data), .REG_RD_DATA(reg_rd_data), .MARGIN_PINS_CFG(margin_pins_cfg),
    .MR_CFG(mr_cfg), .GPIO6_FUNC(gpio6_func), .WDT_CFG_HI(wdt_cfg_hi), .WDT_CFG_LO(wdt_cfg_lo),
    .WDI_CFG(wdi_cfg), .DAC_EN_CFG(dac_en_cfg), .SW_MARGIN(sw_margin), .GPIO_IN(gpio_in),
    .SEQ_FAULT(seq_fault), .FAULT_PU_CLEAR(fault_pu_clear), .WDT_EXPIRED(wdt_expired),
    .RST_TIMEOUT_CYC(rst_timeout_cyc), .FAULT_LINE_ONE_IN(fault_line_one_in), .FAULT_LINE_TWO_IN(fault_line_two_in),
    .ANY_FAULT_IN(any_fault_in), .RESET_REQ_IN(reset_req_in), .EN_REQ(en_req),
    .DAC_SET_SEL(dac_set_sel), .DAC_SW_CLOSED(dac_sw_closed), .MARGIN_ACTIVE(margin_active),
    .FAULT_LINE_ONE_OUT(fault_line_one_out), .FAULT_LINE_TWO_OUT(fault_line_two_out), .ANY_FAULT_OUT(any_fault_out),
    .RESET_N_OUT(reset_n_out), .FAULT_LOG_SAVE(fault_log_save), .GPIO6_OUT(gpio6_out),
    .GPIO6_OE(gpio6_oe), .WD_KICK(wd_kick), .EN_OUT_O(en_out_o), .EN_OUT_OE(en_out_oe),
    .EN_TRACK(en_track), .EN_PUMP(en_pump));
  gfe_board gfe_board_i (.pin_req(pin_req), .gpio6_out(gpio6_out), .gpio6_oe(gpio6_oe),
    .en_out_o(en_out_o), .en_out_oe(en_out_oe), .gpio_in(gpio_in), .en_pin(en_pin));

  // clock at 8 ns
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    cyc(2);
    chk(reg_rd_data, exp, "register read");
  endtask

  // packs nine mode codes into the three mode registers
  task automatic set_modes(input logic [2:0] m[9]);
    wr(GFE_OFS_MODE_LOW, {m[2][1:0], m[1], m[0]}); // field layout
    wr(GFE_OFS_MODE_MID, {m[5][0], m[4], m[3], m[2][2]}); // field layout
    wr(GFE_OFS_MODE_HIGH, {m[8][1:0], m[7][1:0], m[6][1:0], m[5][2:1]}); // field layout
  endtask

  task automatic t_regs();
    rd_chk(GFE_OFS_MODE_LOW, GFE_RST_MODE_LOW); // reset value
    rd_chk(GFE_OFS_MODE_HIGH, GFE_RST_MODE_HIGH); // reset value
    wr(GFE_OFS_MODE_LOW, 8'hd2);
    wr(GFE_OFS_MODE_MID, 8'h6b);
    wr(GFE_OFS_MODE_HIGH, 8'hb9);
    wr(8'h22, 8'hff);
    rd_chk(GFE_OFS_MODE_LOW, 8'hd2); // read back
    rd_chk(GFE_OFS_MODE_MID, 8'h6b); // read back
    rd_chk(GFE_OFS_MODE_HIGH, 8'hb9); // read back
    rd_chk(8'h22, 8'h00);
    done("regs");
  endtask

  task automatic t_modes();
    logic [2:0] m[9];
    logic [2:0] e;
    logic r;
    for (int c = 0; c < 8; c++) begin
      for (int k = 0; k < 2; k++) begin
        r = k[0];
        foreach (m[i]) m[i] = c[2:0];
        set_modes(m);
        @(posedge ref_clk);
        en_req <= {GFE_NUM_EN{r}};
        cyc(4);
        for (int i = 0; i < GFE_NUM_EN; i++) begin
          e = (i >= 6) ? {1'b0, m[i][1:0]} : m[i];
          if (e > 3'h5 || (i >= 4 && i < 6 && e == 3'h4)) begin
            chk(en_out_oe[i], 1'b0, "reserved code drives"); // released output
          end else if (e < 3'h4) begin
            chk(en_pin[i], r ^ !e[0], "enable level"); // polarity
            chk(en_out_oe[i], e[1] | !(r ^ !e[0]), "enable drive"); // drive style
          end else if (r) begin
            chk({en_track[i], en_pump[i]}, {e == 3'h4, e == 3'h5}, "special mode"); // track and pump
          end
        end
      end
    end
    done("modes");
  endtask

  task automatic t_margin_pins();
    logic [1:0] s;
    @(posedge ref_clk);
    margin_pins_cfg <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      s = (k == 1) ? GFE_SET_LOWER : (k == 2) ? GFE_SET_RAISE : GFE_SET_NOMINAL;
      @(posedge ref_clk);
      pin_req[2:1] <= {k[1], k[0]};
      cyc(5);
      chk(dac_set_sel, s, "trim set"); // pin decode
      chk(dac_sw_closed, (s != 2'h0) ? 12'hfff : dac_en_cfg, "trim switches"); // switch state
      chk(margin_active, s != 2'h0, "margin from pins"); // auto margin
    end
    @(posedge ref_clk);
    margin_pins_cfg <= 1'b0;
    pin_req[2:1] <= 2'h3;
    done("margin_pins");
  endtask

  task automatic t_freeze();
    int n;
    @(posedge ref_clk);
    gpio6_func <= GFE_G6_SUSPEND;
    cyc(5);
    chk(margin_active, 1'b0, "margin idle"); // suspend high
    @(posedge ref_clk);
    pin_req[5] <= 1'b0;
    cyc(5);
    chk(margin_active, 1'b1, "margin on suspend"); // suspend low
    @(posedge ref_clk);
    {fault_line_one_in, fault_line_two_in, any_fault_in, reset_req_in} <= 4'hf;
    cyc(5);
    chk({fault_line_one_out, fault_line_two_out, any_fault_out, reset_n_out}, 4'h1, "frozen outputs"); // freeze
    @(posedge ref_clk);
    pin_req[5] <= 1'b1;
    cyc(6);
    chk({fault_line_one_out, fault_line_two_out, any_fault_out, reset_n_out}, 4'he, "thawed outputs"); // release
    @(posedge ref_clk);
    {fault_line_one_in, fault_line_two_in, any_fault_in, reset_req_in} <= 4'h0;
    gpio6_func <= GFE_G6_FAULT_PU;
    sw_margin <= 1'b1;
    seq_fault <= 1'b1;
    n = 0;
    repeat (6) begin
      cyc(1);
      n += fault_log_save;
    end
    chk(margin_active, 1'b1, "software margin"); // register bit
    chk(n, 0, "logging while margining"); // no logging
    @(posedge ref_clk);
    seq_fault <= 1'b0;
    sw_margin <= 1'b0;
    gpio6_func <= GFE_G6_NONE;
    done("freeze");
  endtask

  task automatic wait_rst_hi(output int n);
    n = 0;
    while (reset_n_out !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic t_manual_reset();
    int n;
    @(posedge ref_clk);
    mr_cfg <= 1'b1;
    wait_rst_hi(n);
    chk(reset_n_out, 1'b1, "reset idle before button"); // released before press
    @(posedge ref_clk);
    pin_req[3] <= 1'b0;
    cyc(4);
    chk(reset_n_out, 1'b0, "reset on button"); // held low
    cyc(20);
    chk(reset_n_out, 1'b0, "reset held"); // held low
    @(posedge ref_clk);
    pin_req[3] <= 1'b1;
    wait_rst_hi(n);
    chk(n >= 12 && n <= 16, 1'b1, "reset timeout length"); // timeout after release
    done("manual_reset");
  endtask

  task automatic t_fault_pu();
    logic [2:0] m[9];
    int n;
    foreach (m[i]) m[i] = GFE_MODE_PP_HIGH;
    set_modes(m);
    @(posedge ref_clk);
    mr_cfg <= 1'b0;
    gpio6_func <= GFE_G6_FAULT_PU;
    en_req <= 9'h1ff;
    cyc(4);
    chk(en_pin, 9'h1ff, "enables on"); // before fault
    @(posedge ref_clk);
    seq_fault <= 1'b1;
    @(posedge ref_clk);
    seq_fault <= 1'b0;
    n = 0;
    repeat (5) begin
      #1;
      n += fault_log_save;
      @(posedge ref_clk);
    end
    cyc(1);
    chk(n, 1, "one log save"); // fault stored
    chk({gpio6_oe, gpio_in[5], en_out_oe, en_out_o}, {2'h2, 9'h1ff, 9'h000}, "fault state"); // pins low
    @(posedge ref_clk);
    fault_pu_clear <= 1'b1;
    @(posedge ref_clk);
    fault_pu_clear <= 1'b0;
    cyc(4);
    chk({gpio6_oe, en_pin}, {1'b0, 9'h1ff}, "fault cleared"); // indicator released
    @(posedge ref_clk);
    gpio6_func <= GFE_G6_NONE;
    done("fault_pu");
  endtask

  task automatic t_watchdog();
    @(posedge ref_clk);
    {wdt_cfg_hi, wdt_cfg_lo} <= GFE_WDO_PATTERN;
    wdt_expired <= 1'b1;
    cyc(4);
    chk({gpio6_oe, gpio6_out, gpio_in[5]}, 3'h4, "expiry pulls low"); // expiry output
    @(posedge ref_clk);
    wdt_expired <= 1'b0;
    cyc(4);
    chk({gpio6_oe, gpio_in[5]}, 2'h1, "expiry released"); // open drain idle
    @(posedge ref_clk);
    wdt_cfg_lo <= 1'b1;
    wdt_expired <= 1'b1;
    cyc(4);
    chk(gpio6_oe, 1'b0, "wrong pattern"); // pattern match only
    @(posedge ref_clk);
    wdi_cfg <= GFE_WDI_PATTERN;
    pin_req[4] <= 1'b1;
    cyc(4);
    chk(wd_kick, 1'b1, "kick high"); // kick input
    @(posedge ref_clk);
    pin_req[4] <= 1'b0;
    cyc(4);
    chk(wd_kick, 1'b0, "kick low"); // kick input
    @(posedge ref_clk);
    pin_req[4] <= 1'b1;
    wdi_cfg <= 3'h6;
    cyc(4);
    chk(wd_kick, 1'b0, "kick unselected"); // pattern match only
    done("watchdog");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_margin_pins();
    t_freeze();
    t_manual_reset();
    t_fault_pu();
    t_watchdog();
    print_verdict();
  end

  // hang guard, well beyond the few hundred cycles the tests take
  initial begin
    #200000;
    err_count++;
    $display("unexpected at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
